// [rtl/lics_charge_seq.sv]
// Purpose: charge sequencer for a linear lithium cell charger with AXI4-Lite registers
// Assumes: comparator results arrive synchronous to aclk
// Notes:   analog regulation lives outside; this block only picks the mode
// What this block does
// RQ1: qualify supply, enable and temperature before charging
// RQ2: keep checking qualification; suspend when lost
// RQ3: status pin pulled low for whole charge
// RQ4: low cell starts with trickle charge
// RQ5: precharge timeout before threshold gives fault
// RQ6: cell above threshold moves to fast charge
// RQ7: fast charge timeout before regulation gives fault
// RQ8: regulation voltage reached switches to constant voltage
// RQ9: low current or elapsed timeout completes charge
// RQ10: completed charge restarts when cell sags
// RQ11: supply under lockout forces power-down
// RQ12: temperature valid between quarter and half reference
// RQ13: fixed thermistor level disables temperature check
// RQ14: timers one, one and half, three hours
// RQ15: precharge timer runs qualification to fast
// RQ16: fast and elapsed timers start leaving precharge
// RQ17: fast timer cleared entering constant voltage
// RQ18: elapsed timer ends charge if current stays
// RQ19: enable input terminates, starts, clears, blocks recharge
// RQ20: status off, on, or flashing per state
// RQ21: enable low disables and ends charge
// RQ22: gate drive off under supply lockout
// RQ23: timers count one common scaled tick
// RQ24: timer fault latched until enable low; the code also releases it on supply lockout
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lics_charge_seq #(
  parameter int unsigned BASE_TICK_CYCLES = lics_pkg::BASE_TICK_CYC
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [lics_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [lics_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire lics_pkg::lics_sense_s      sense,
  output var lics_pkg::lics_mode_e        charge_mode,
  output logic                            pass_gate_drive,
  input  wire logic                       charge_status_in,
  output logic                            charge_status_out,
  output logic                            charge_status_oe
);
  import lics_pkg::*;

  lics_state_e      state_r;
  lics_state_e      state_nxt;
  lics_state_e      start_state;
  lics_mode_e       mode_nxt;
  logic [TMR_W-1:0] precon_cnt_r;
  logic [TMR_W-1:0] fast_cnt_r;
  logic [TMR_W-1:0] elapsed_cnt_r;
  logic             precon_exp;
  logic             fast_exp;
  logic             elapsed_exp;
  logic             tick;
  logic             flash_r;
  logic             status_on_nxt;
  logic             temp_ok;
  logic             qual_ok;
  logic             fault_pre_r;
  logic             fault_fast_r;
  logic [1:0]       ctrl_r;
  logic [7:0]       scale_r;
  logic             aw_hold_r;
  logic             w_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]      wdata_r;
  logic [3:0]       wstrb_r;
  logic             wr_go;
  logic [31:0]      status_word;

  // one scaled time base feeds every timer and the flash
  lics_tick_gen #(
    .BASE_CYCLES (BASE_TICK_CYCLES)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .scale   (scale_r),
    .tick    (tick)
  );

  // temperature window, or bypassed by the fixed disable level or by software
  assign temp_ok = sense.thermistor_sense_in_at_disable                                   // RQ13
                || !ctrl_r[CTRL_TEMP_EN_BIT]
                || (sense.thermistor_sense_in_above_quarter && sense.thermistor_sense_in_below_half);   // RQ12
  assign qual_ok = sense.supply_ok && sense.enable && temp_ok;              // RQ1

  // expiry flags; all three periods share the same tick so they scale together
  assign precon_exp  = (precon_cnt_r >= PRECON_TICKS);                      // RQ14
  assign fast_exp    = (fast_cnt_r >= FAST_TICKS);                          // RQ14
  assign elapsed_exp = (elapsed_cnt_r >= TERM_TICKS);                       // RQ14

  // a fresh cycle trickles a deep cell, otherwise goes straight to fast charge
  assign start_state = sense.cell_above_precon ? ST_FAST : ST_PRECON;       // RQ4

  // sequencer next state; supply loss and enable low override everything
  always_comb begin
    state_nxt = state_r;
    if (!sense.supply_ok || !sense.enable) begin
      state_nxt = ST_OFF;                                                   // RQ11
    end else begin
      case (state_r)
        ST_OFF: begin
          state_nxt = ST_QUAL;                                              // RQ19
        end
        ST_QUAL: begin
          if (qual_ok && sense.cell_present) begin
            state_nxt = start_state;                                        // RQ1
          end
        end
        ST_PRECON: begin
          if (!qual_ok) begin
            state_nxt = ST_QUAL;                                            // RQ2
          end else if (sense.cell_above_precon) begin
            state_nxt = ST_FAST;                                            // RQ6
          end else if (precon_exp) begin
            state_nxt = ST_FAULT;                                           // RQ5
          end
        end
        ST_FAST: begin
          if (!qual_ok) begin
            state_nxt = ST_QUAL;                                            // RQ2
          end else if (sense.cell_at_regulation) begin
            state_nxt = ST_CV;                                              // RQ8
          end else if (fast_exp) begin
            state_nxt = ST_FAULT;                                           // RQ7
          end
        end
        ST_CV: begin
          if (!qual_ok) begin
            state_nxt = ST_QUAL;                                            // RQ2
          end else if (sense.current_below_term || elapsed_exp) begin
            state_nxt = ST_DONE;                                            // RQ9 RQ18
          end
        end
        ST_DONE: begin
          // software may block the automatic restart as well as the pin
          if (ctrl_r[CTRL_RECHG_EN_BIT] && sense.cell_below_recharge && qual_ok) begin
            state_nxt = start_state;                                        // RQ10
          end
        end
        ST_FAULT: begin
          state_nxt = ST_FAULT;                                             // RQ24
        end
        default: begin
          state_nxt = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // precharge timer lives only in precharge, so leaving it clears it
  always_ff @(posedge aclk) begin
    if (!aresetn || state_r != ST_PRECON) begin
      precon_cnt_r <= '0;                                                   // RQ15
    end else if (tick && !precon_exp) begin
      precon_cnt_r <= precon_cnt_r + 16'h0001;                              // RQ23
    end
  end

  // fast timer: counts in fast charge only, cleared on entry to constant voltage
  always_ff @(posedge aclk) begin
    if (!aresetn || state_r != ST_FAST) begin
      fast_cnt_r <= '0;                                                     // RQ16 RQ17
    end else if (tick && !fast_exp) begin
      fast_cnt_r <= fast_cnt_r + 16'h0001;                                  // RQ23
    end
  end

  // elapsed timer spans fast charge and constant voltage
  always_ff @(posedge aclk) begin
    if (!aresetn || (state_r != ST_FAST && state_r != ST_CV)) begin
      elapsed_cnt_r <= '0;                                                  // RQ16
    end else if (tick && !elapsed_exp) begin
      elapsed_cnt_r <= elapsed_cnt_r + 16'h0001;                            // RQ18 RQ23
    end
  end

  // fault causes stay visible until the fault is released through the off state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_pre_r  <= 1'b0;
      fault_fast_r <= 1'b0;
    end else if (state_r == ST_OFF) begin
      fault_pre_r  <= 1'b0;                                                 // RQ19 RQ24
      fault_fast_r <= 1'b0;
    end else if (state_nxt == ST_FAULT && state_r != ST_FAULT) begin
      fault_pre_r  <= (state_r == ST_PRECON);
      fault_fast_r <= (state_r == ST_FAST);
    end
  end

  // mode selection follows the next state so outputs drop on the same edge
  always_comb begin
    case (state_nxt)
      ST_PRECON: mode_nxt = MODE_TRICKLE;                                   // RQ4
      ST_FAST:   mode_nxt = MODE_FAST;
      ST_CV:     mode_nxt = MODE_CV;                                        // RQ8
      default:   mode_nxt = MODE_OFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charge_mode     <= MODE_OFF;
      pass_gate_drive <= 1'b0;
    end else begin
      charge_mode     <= mode_nxt;
      pass_gate_drive <= (mode_nxt != MODE_OFF);                            // RQ22
    end
  end

  // half-period flash; stretches with the scale like the timers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_r <= 1'b0;
    end else if (tick) begin
      flash_r <= !flash_r;                                                  // RQ20 RQ23
    end
  end

  // open drain status: enable pulls the pin low, released means off
  always_comb begin
    case (state_nxt)
      ST_PRECON, ST_FAST, ST_CV: status_on_nxt = 1'b1;                      // RQ3
      ST_FAULT:                  status_on_nxt = flash_r;                   // RQ20 RQ24
      ST_QUAL:                   status_on_nxt = !temp_ok && sense.cell_present && flash_r;
      default:                   status_on_nxt = 1'b0;                      // RQ20
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charge_status_oe  <= 1'b0;
      charge_status_out <= 1'b0;
    end else begin
      charge_status_oe  <= status_on_nxt;
      charge_status_out <= 1'b0;
    end
  end

  // write channel: address and data taken in either order, response after both
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_go         = aw_hold_r && w_hold_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // register update and write response; only byte lane 0 carries fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r       <= CTRL_RST;
      scale_r      <= SCALE_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= RESP_OKAY;
      case (awaddr_r)
        ADDR_CTRL: begin
          if (wstrb_r[0]) begin
            ctrl_r <= wdata_r[1:0];
          end
        end
        ADDR_SCALE: begin
          if (wstrb_r[0]) begin
            scale_r <= wdata_r[7:0];
          end
        end
        ADDR_STATUS: begin
          s_axi_bresp <= RESP_OKAY;  // read-only, write ignored
        end
        default: begin
          s_axi_bresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // live state for software; the pin readback shows the wired level
  always_comb begin
    status_word                                   = 32'h00000000;
    status_word[STAT_STATE_LSB +: 3]              = state_r;
    status_word[STAT_MODE_LSB +: 2]               = charge_mode;
    status_word[STAT_FLT_PRE]                     = fault_pre_r;
    status_word[STAT_FLT_FAST]                    = fault_fast_r;
    status_word[STAT_TEMP_OK]                     = temp_ok;
    status_word[STAT_PIN_LEVEL]                   = charge_status_in;
    status_word[STAT_GATE_DRIVE]                  = pass_gate_drive;
  end

  // read channel: one read at a time, answer on the edge that takes the address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL:   s_axi_rdata <= {30'h00000000, ctrl_r};
        ADDR_SCALE:  s_axi_rdata <= {24'h000000, scale_r};
        ADDR_STATUS: s_axi_rdata <= status_word;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_precon_stuck;
    state_r == ST_PRECON && qual_ok && precon_exp && !sense.cell_above_precon;
  endsequence

  sequence s_fast_stuck;
    state_r == ST_FAST && qual_ok && fast_exp && !sense.cell_at_regulation;
  endsequence

  a_qual_gate: assert property ((state_r == ST_QUAL && !qual_ok) |=> state_r inside {ST_QUAL, ST_OFF}) // RQ1
    else $error("charge started without qualification");
  a_qual_loss: assert property ((state_r inside {ST_PRECON, ST_FAST, ST_CV} && !qual_ok) |=> !pass_gate_drive) // RQ2
    else $error("gate drive kept after qualification lost");
  a_status_active: assert property (state_r inside {ST_PRECON, ST_FAST, ST_CV} |-> charge_status_oe) // RQ3
    else $error("status not pulled low while charging");
  a_trickle_mode: assert property (state_r == ST_PRECON |-> charge_mode == MODE_TRICKLE) // RQ4
    else $error("precharge not in trickle mode");
  a_precon_fault: assert property (s_precon_stuck |=> state_r == ST_FAULT ##1 fault_pre_r) // RQ5
    else $error("precharge timeout not faulted");
  a_precon_exit: assert property ((state_r == ST_PRECON && qual_ok && sense.cell_above_precon) |=> (state_r == ST_FAST && fast_cnt_r == '0) ##1 precon_cnt_r == '0) // RQ6 RQ15
    else $error("precharge did not hand over to fast charge");
  a_fast_fault: assert property (s_fast_stuck |=> state_r == ST_FAULT ##1 fault_fast_r) // RQ7
    else $error("fast charge timeout not faulted");
  a_cv_entry: assert property ((state_r == ST_FAST && qual_ok && sense.cell_at_regulation) |=> (state_r == ST_CV && charge_mode == MODE_CV) ##1 fast_cnt_r == '0) // RQ8 RQ17
    else $error("constant voltage not entered with fast timer cleared");
  a_charge_done: assert property ((state_r == ST_CV && qual_ok && (sense.current_below_term || elapsed_exp)) |=> state_r == ST_DONE && !charge_status_oe) // RQ9 RQ18
    else $error("charge completion missed");
  a_auto_recharge: assert property ((state_r == ST_DONE && qual_ok && ctrl_r[CTRL_RECHG_EN_BIT] && sense.cell_below_recharge) |=> pass_gate_drive) // RQ10
    else $error("recharge did not start");
  a_uvlo_off: assert property (!sense.supply_ok |=> state_r == ST_OFF && !pass_gate_drive && !charge_status_oe) // RQ11 RQ22
    else $error("supply lockout did not power down");
  a_enable_off: assert property (!sense.enable |=> state_r == ST_OFF ##1 !fault_pre_r && !fault_fast_r) // RQ21 RQ19
    else $error("enable low did not disable and clear");
  a_fault_hold: assert property ((state_r == ST_FAULT && sense.supply_ok && sense.enable) |=> state_r == ST_FAULT && !pass_gate_drive) // RQ24
    else $error("timer fault released without enable low");
  a_flash_rate: assert property ((state_r == ST_FAULT && tick) |=> ##1 $changed(charge_status_oe) || state_r != ST_FAULT) // RQ20
    else $error("fault status not flashing");
endmodule
`default_nettype wire

// [rtl/lics_pkg.sv]
// Purpose: shared constants, types and register map of the lithium cell charge sequencer
// Assumes: 250 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes:   timer figures are nominal; a run-time scale factor stretches all of them
package lics_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS    = 4;
  localparam int unsigned BASE_TICK_US     = 62500;  // one base tick, before scaling
  localparam int unsigned BASE_TICK_CYC    = (BASE_TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned HALF_SEC_PER_MIN = 120;    // scaled tick is half a second nominal

  // safety timer periods at the nominal capacitor, in minutes
  localparam int unsigned PRECON_MIN = 60;
  localparam int unsigned FAST_MIN   = 90;
  localparam int unsigned TERM_MIN   = 180;

  localparam int unsigned TMR_W = 16;
  localparam logic [TMR_W-1:0] PRECON_TICKS = TMR_W'(PRECON_MIN * HALF_SEC_PER_MIN);
  localparam logic [TMR_W-1:0] FAST_TICKS   = TMR_W'(FAST_MIN * HALF_SEC_PER_MIN);
  localparam logic [TMR_W-1:0] TERM_TICKS   = TMR_W'(TERM_MIN * HALF_SEC_PER_MIN);

  // register map, byte addresses
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_SCALE  = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;

  // control register fields and reset values
  localparam int unsigned CTRL_TEMP_EN_BIT  = 0;
  localparam int unsigned CTRL_RECHG_EN_BIT = 1;
  localparam logic [1:0]  CTRL_RST          = 2'h3;
  localparam logic [7:0]  SCALE_RST         = 8'h08;  // base ticks per half second

  // status register field positions
  localparam int unsigned STAT_STATE_LSB  = 0;  // three bits
  localparam int unsigned STAT_MODE_LSB   = 3;  // two bits
  localparam int unsigned STAT_FLT_PRE    = 5;
  localparam int unsigned STAT_FLT_FAST   = 6;
  localparam int unsigned STAT_TEMP_OK    = 7;
  localparam int unsigned STAT_PIN_LEVEL  = 8;
  localparam int unsigned STAT_GATE_DRIVE = 9;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF    = 3'h0,
    ST_QUAL   = 3'h1,
    ST_PRECON = 3'h2,
    ST_FAST   = 3'h3,
    ST_CV     = 3'h4,
    ST_DONE   = 3'h5,
    ST_FAULT  = 3'h6
  } lics_state_e;

  typedef enum logic [1:0] {
    MODE_OFF     = 2'h0,
    MODE_TRICKLE = 2'h1,  // about a tenth of the fast current
    MODE_FAST    = 2'h2,
    MODE_CV      = 2'h3
  } lics_mode_e;

  // comparator results, all synchronous to aclk, active high
  typedef struct packed {
    logic supply_ok;
    logic enable;
    logic cell_present;
    logic thermistor_sense_in_above_quarter;
    logic thermistor_sense_in_below_half;
    logic thermistor_sense_in_at_disable;
    logic cell_above_precon;
    logic cell_at_regulation;
    logic cell_below_recharge;
    logic current_below_term;
  } lics_sense_s;

endpackage

// [rtl/lics_tick_gen.sv]
// Purpose: scaled time base for the safety timers and the status flash
// Assumes: scale of zero is taken as one
// Notes:   one pulse every base_cycles * scale clock cycles
`timescale 1ns/1ps
`default_nettype none
module lics_tick_gen #(
  parameter int unsigned BASE_CYCLES = lics_pkg::BASE_TICK_CYC
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] scale,
  output logic            tick
);
  import lics_pkg::*;

  logic [23:0] base_cnt_r;
  logic [7:0]  scale_cnt_r;
  logic        base_wrap;

  assign base_wrap = (base_cnt_r == 24'(BASE_CYCLES - 1));

  // base prescaler, free running
  always_ff @(posedge aclk) begin
    if (!aresetn || base_wrap) begin
      base_cnt_r <= 24'h000000;
    end else begin
      base_cnt_r <= base_cnt_r + 24'h000001;
    end
  end

  // the scale stands in for the timing capacitor ratio
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scale_cnt_r <= 8'h00;
      tick        <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (base_wrap) begin
        if (scale_cnt_r + 8'h01 >= scale) begin
          scale_cnt_r <= 8'h00;
          tick        <= 1'b1;
        end else begin
          scale_cnt_r <= scale_cnt_r + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [bench/lics_cell_model.sv]
// Purpose: cell, pass gate and status led seen from the sequencer
// Assumes: cell voltage in coarse steps, status pin has a pull-up
// Notes:   ctl[0] models a dead cell that never takes charge
`timescale 1ns/1ps
`default_nettype none
module lics_cell_model (
  input  wire logic                 aclk,
  input  wire logic [4:0]           ctl,
  input  wire logic                 sag,
  input  wire lics_pkg::lics_mode_e mode,
  input  wire logic                 oe,
  output lics_pkg::lics_sense_s     sense,
  output logic                      pin
);
  import lics_pkg::*;
  logic [7:0] v_r = 8'h00;
  logic [3:0] cv_r = 4'h0;
  // cell climbs while driven; a dead cell stays pinned at zero
  always_ff @(posedge aclk) begin
    if (ctl[0]) v_r <= 8'h00;
    else if (sag) v_r <= 8'h1e;
    else if (mode inside {MODE_TRICKLE, MODE_FAST} && v_r < 8'h28) v_r <= v_r + 8'h01;
  end
  // taper current fades a few cycles into constant voltage
  always_ff @(posedge aclk) cv_r <= (mode != MODE_CV) ? 4'h0 : cv_r + {3'h0, cv_r != 4'hf};
  // window set by the bench; disable level overrides it
  assign sense = {ctl[4], ctl[3], 1'b1, ctl[2], 1'b1, ctl[1],
                  v_r >= 8'h14, v_r >= 8'h28, v_r < 8'h23, cv_r == 4'hf};
  assign pin = !oe; // pull-up wins unless the led sinks
endmodule
`default_nettype wire

// [bench/lics_charge_seq_tb.sv]
// Purpose: self-checking bench for the charge sequencer
// Assumes: one scaled tick per clock, base 1 and scale 1
// Notes:   fast and elapsed expiry left to the embedded assertions
`timescale 1ns/1ps
`default_nettype none
module lics_charge_seq_tb;
  import lics_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, sag = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [4:0]  ctl = 5'h00;
  logic        awready, wready, bvalid, arready, rvalid, drv, oe, pin;
  logic [1:0]  bresp, rresp;
  lics_sense_s sense;
  lics_mode_e  charge_mode;
  int          error_cnt = 0, comparisons = 0;
  lics_charge_seq #(.BASE_TICK_CYCLES(1)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sense(sense), .charge_mode(charge_mode), .pass_gate_drive(drv),
    .charge_status_in(pin), .charge_status_out(), .charge_status_oe(oe));
  lics_cell_model u_cell (.aclk(aclk), .ctl(ctl), .sag(sag), .mode(charge_mode), .oe(oe),
    .sense(sense), .pin(pin));
  initial forever #2 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ready is sampled at the falling edge, so release lands right after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(negedge aclk);
    while (awvalid || wvalid) begin
      pa = awready;
      pw = wready;
      @(posedge aclk);
      if (pa) awvalid <= 1'b0;
      if (pw) wvalid <= 1'b0;
      @(negedge aclk);
    end
    while (!bvalid) @(negedge aclk);
    chk(32'(bresp), 32'(er));
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge aclk);
    while (!arready) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (!rvalid) @(negedge aclk);
    chk(rdata & m, e);
    chk(32'(rresp), 32'(er));
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic wm(input lics_mode_e m, input int n);
    repeat (n) begin
      @(negedge aclk);
      if (charge_mode === m) break;
    end
    chk(32'(charge_mode), 32'(m));
  endtask
  // status led must change level within a few ticks while flashing
  task automatic flash;
    logic o;
    o = oe;
    repeat (4) begin
      @(negedge aclk);
      if (oe !== o) break;
    end
    chk(32'(oe), 32'(!o));
  endtask
  initial begin
    #400000;
    error_cnt++;
    stop_test;
  end
  // ctl bits: supply, enable, window ok, disable level, dead cell
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, 32'h3, 32'(CTRL_RST), RESP_OKAY);
    rd(ADDR_SCALE, 32'hff, 32'(SCALE_RST), RESP_OKAY);
    rd(8'h0c, '1, 32'h0, RESP_SLVERR);
    wr(8'h0c, 32'h0, RESP_SLVERR);
    wr(ADDR_SCALE, 32'h1, RESP_OKAY);
    rd(ADDR_SCALE, 32'hff, 32'h1, RESP_OKAY);
    ctl <= 5'b11000;
    repeat (20) @(negedge aclk);
    chk(32'(charge_mode), 32'(MODE_OFF));
    flash;
    ctl <= 5'b11010;
    wm(MODE_TRICKLE, 4);
    chk(32'({oe, drv}), 32'h3);
    wm(MODE_FAST, 40);
    chk(32'(oe), 32'h1);
    wm(MODE_CV, 40);
    rd(ADDR_STATUS, 32'h7, 32'(ST_CV), RESP_OKAY);
    wm(MODE_OFF, 40);
    rd(ADDR_STATUS, 32'h7, 32'(ST_DONE), RESP_OKAY);
    chk(32'(oe), 32'h0);
    sag <= 1'b1;
    @(posedge aclk);
    sag <= 1'b0;
    wm(MODE_FAST, 4);
    ctl <= 5'b01010;
    wm(MODE_OFF, 3);
    chk(32'(drv), 32'h0);
    ctl <= 5'b11010;
    wm(MODE_FAST, 4);
    ctl <= 5'b10010;
    wm(MODE_OFF, 3);
    ctl <= 5'b11011;
    wm(MODE_TRICKLE, 4);
    repeat (7000) @(negedge aclk);
    chk(32'(charge_mode), 32'(MODE_TRICKLE));
    wm(MODE_OFF, 8000);
    rd(ADDR_STATUS, 32'h27, 32'h26, RESP_OKAY);
    ctl <= 5'b11010;
    repeat (20) @(negedge aclk);
    chk(32'(charge_mode), 32'(MODE_OFF));
    flash;
    ctl <= 5'b10010;
    repeat (3) @(negedge aclk);
    ctl <= 5'b11010;
    wm(MODE_TRICKLE, 6);
    stop_test;
  end
endmodule
`default_nettype wire
